// *** analog_threshold_compare_defs.vh ***
// constants for the analog threshold compare unit
`ifndef ANALOG_THRESHOLD_COMPARE_DEFS_VH
`define ANALOG_THRESHOLD_COMPARE_DEFS_VH
`define ATC_IN_W         16
`define ATC_RAW_MAX      16'h03E8
`define ATC_GAIN_W       12
`define ATC_GAIN_MAX     12'h3E8
`define ATC_OFFS_W       16
`define ATC_OFFS_MAX     16'h2710
`define ATC_THR_W        16
`define ATC_THR_MAX      16'h4E20
`define ATC_GAIN_SCALE   32'sd100
`define ATC_VAL_W        32
`define ATC_MODE_DIFF    1'b0
`define ATC_MODE_CMP     1'b1
`define ATC_DEC_MAX      2'h3
`define ATC_SEL_W        4
`endif

// *** analog_threshold_compare.v ***
// analog threshold compare unit: differential trigger and comparator modes
// What this block does
// - actual value is raw input times gain plus zero offset, before comparing
// - gain is signed hundredths within plus/minus ten; offset within plus/minus ten thousand
// - differential mode derives off threshold as on threshold plus signed differential
// - differential mode on threshold and differential each within plus/minus twenty thousand
// - negative differential: set above on, clear at or below off
// - positive differential: high only while on <= value < off
// - comparator mode scales both inputs with the same gain and offset
// - comparator compares first scaled input minus second scaled input
// - on not below off: set above on, clear at or below off
// - on below off: high only while on <= difference < off
// - comparator on and off thresholds each within plus/minus twenty thousand
// - each comparator threshold may come from another function's actual value
// - comparison uses raw integers; decimal places setting only affects presentation
// - a full-range analog channel gives raw values zero to one thousand
`timescale 1ns/1ps
`include "analog_threshold_compare_defs.vh"
module analog_threshold_compare #(
  parameter SEL_N = 8
) (
  input  wire                            clk,
  input  wire                            srst,
  input  wire                            evalEn,
  input  wire                            mode,
  input  wire signed [`ATC_IN_W-1:0]     firstAnalogInput,
  input  wire signed [`ATC_IN_W-1:0]     secondAnalogInput,
  input  wire signed [`ATC_GAIN_W-1:0]   gain,
  input  wire signed [`ATC_OFFS_W-1:0]   zeroOffset,
  input  wire signed [`ATC_THR_W-1:0]    onThreshold,
  input  wire signed [`ATC_THR_W-1:0]    offThreshold,
  input  wire signed [`ATC_THR_W-1:0]    differential,
  input  wire                            onFromBlock,
  input  wire                            offFromBlock,
  input  wire [`ATC_SEL_W-1:0]           onBlockSel,
  input  wire [`ATC_SEL_W-1:0]           offBlockSel,
  input  wire [SEL_N*`ATC_VAL_W-1:0]     blockValues,
  input  wire [1:0]                      decimals,
  output reg                             q_q,
  output reg  signed [`ATC_VAL_W-1:0]    actualValue_q,
  output reg                             paramError_q
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // scaled value: raw * gain/100 + offset, truncated toward zero
  function signed [`ATC_VAL_W-1:0] scaleValue;
    input signed [`ATC_IN_W-1:0]   raw;
    input signed [`ATC_GAIN_W-1:0] g;
    input signed [`ATC_OFFS_W-1:0] offs;
    reg   signed [`ATC_VAL_W-1:0]  prod;
    begin
      prod = $signed({{(`ATC_VAL_W-`ATC_IN_W){raw[`ATC_IN_W-1]}}, raw})
           * $signed({{(`ATC_VAL_W-`ATC_GAIN_W){g[`ATC_GAIN_W-1]}}, g});
      scaleValue = prod / `ATC_GAIN_SCALE
                 + $signed({{(`ATC_VAL_W-`ATC_OFFS_W){offs[`ATC_OFFS_W-1]}}, offs});
    end
  endfunction

  function signed [`ATC_VAL_W-1:0] extThr;
    input signed [`ATC_THR_W-1:0] t;
    begin
      extThr = $signed({{(`ATC_VAL_W-`ATC_THR_W){t[`ATC_THR_W-1]}}, t});
    end
  endfunction

  function inRange;
    input signed [`ATC_VAL_W-1:0] v;
    input signed [`ATC_VAL_W-1:0] lim;
    begin
      inRange = (v <= lim) && (v >= -lim);
    end
  endfunction

  function signed [`ATC_VAL_W-1:0] pickBlock;
    input [SEL_N*`ATC_VAL_W-1:0] vals;
    input [`ATC_SEL_W-1:0]       sel;
    integer i;
    begin
      pickBlock = {`ATC_VAL_W{1'b0}};
      for (i = 0; i < SEL_N; i = i + 1) begin
        if (sel == i[`ATC_SEL_W-1:0]) begin
          pickBlock = vals[i*`ATC_VAL_W +: `ATC_VAL_W];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // scaling and thresholds
  // ------------------------------------------------------------
  // decimals input is presentation only and is never read here
  wire signed [`ATC_VAL_W-1:0] scaledFirst  = scaleValue(firstAnalogInput, gain, zeroOffset);
  wire signed [`ATC_VAL_W-1:0] scaledSecond = scaleValue(secondAnalogInput, gain, zeroOffset);
  wire signed [`ATC_VAL_W-1:0] cmpDiff = scaledFirst - scaledSecond;

  wire signed [`ATC_VAL_W-1:0] cmpOn  = onFromBlock ?
    pickBlock(blockValues, onBlockSel) : extThr(onThreshold);
  wire signed [`ATC_VAL_W-1:0] cmpOff = offFromBlock ?
    pickBlock(blockValues, offBlockSel) : extThr(offThreshold);

  wire signed [`ATC_VAL_W-1:0] diffOff = extThr(onThreshold) + extThr(differential);

  // ------------------------------------------------------------
  // parameter range checks
  // ------------------------------------------------------------
  // range flags only feed the error output; evaluation goes on regardless
  wire signed [`ATC_VAL_W-1:0] thrLimit  = extThr(`ATC_THR_MAX);
  wire signed [`ATC_VAL_W-1:0] gainWide  =
    $signed({{(`ATC_VAL_W-`ATC_GAIN_W){gain[`ATC_GAIN_W-1]}}, gain});
  wire signed [`ATC_VAL_W-1:0] gainLimit =
    $signed({{(`ATC_VAL_W-`ATC_GAIN_W){1'b0}}, `ATC_GAIN_MAX});
  wire signed [`ATC_VAL_W-1:0] offsWide  =
    $signed({{(`ATC_VAL_W-`ATC_OFFS_W){zeroOffset[`ATC_OFFS_W-1]}}, zeroOffset});
  wire signed [`ATC_VAL_W-1:0] offsLimit =
    $signed({{(`ATC_VAL_W-`ATC_OFFS_W){1'b0}}, `ATC_OFFS_MAX});

  wire gainOk    = inRange(gainWide, gainLimit);
  wire offsOk    = inRange(offsWide, offsLimit);
  wire rawOk     = (firstAnalogInput >= $signed(16'h0000)) &&
                   (firstAnalogInput <= $signed(`ATC_RAW_MAX));
  wire cmpThrOk  = inRange(cmpOn, thrLimit) && inRange(cmpOff, thrLimit);
  wire diffThrOk = inRange(extThr(onThreshold), thrLimit) &&
                   inRange(extThr(differential), thrLimit);

  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  reg signed [`ATC_VAL_W-1:0] value;
  reg signed [`ATC_VAL_W-1:0] thrOn;
  reg signed [`ATC_VAL_W-1:0] thrOff;
  reg                         paramOk;

  always @* begin
    case (mode)
      `ATC_MODE_CMP: begin
        value   = cmpDiff;
        thrOn   = cmpOn;
        thrOff  = cmpOff;
        paramOk = cmpThrOk;
      end
      default: begin
        value   = scaledFirst;
        thrOn   = extThr(onThreshold);
        thrOff  = diffOff;
        paramOk = diffThrOk;
      end
    endcase
  end

  wire paramAllOk = paramOk && gainOk && offsOk && rawOk;

  // ------------------------------------------------------------
  // output decision
  // ------------------------------------------------------------
  // on at or above off selects the hysteresis band, else the window
  wire hystMode  = (thrOn >= thrOff);
  wire setHit    = (value > thrOn);
  wire clearHit  = (value <= thrOff);
  wire windowHit = (value >= thrOn) && (value < thrOff);

  reg q_d;
  always @* begin
    if (hystMode) begin
      if (setHit) begin
        q_d = 1'b1;
      end else if (clearHit) begin
        q_d = 1'b0;
      end else begin
        q_d = q_q;
      end
    end else begin
      q_d = windowHit;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      q_q           <= 1'b0;
      actualValue_q <= {`ATC_VAL_W{1'b0}};
      paramError_q  <= 1'b0;
    end else if (evalEn) begin
      q_q           <= q_d;
      actualValue_q <= value;
      paramError_q  <= ~paramAllOk;
    end
  end

endmodule // analog_threshold_compare

// *** block_value_source.sv ***
// model of the other blocks that feed their actual values in
`timescale 1ns/1ps
module block_value_source (
  input  wire         clk,
  input  wire         load,
  input  wire [31:0]  loadVal,
  output reg  [255:0] blockValues = 256'h0
);
  always @(posedge clk) if (load) blockValues <= {blockValues[223:0], loadVal};
endmodule // block_value_source

// *** analog_threshold_compare_properties.sv ***
// assertions for the analog threshold compare unit
`timescale 1ns/1ps
module analog_threshold_compare_properties (
  input wire clk, srst, evalEn, mode, onFromBlock, offFromBlock, q_q, paramError_q,
  input wire signed [15:0] firstAnalogInput, secondAnalogInput, zeroOffset,
  input wire signed [15:0] onThreshold, offThreshold, differential,
  input wire signed [11:0] gain,
  input wire signed [31:0] actualValue_q
);
  function automatic logic signed [31:0] scl(input logic signed [15:0] r,
    input logic signed [11:0] g, input logic signed [15:0] o);
    return r * g / 100 + o;
  endfunction
  wire signed [31:0] a = scl(firstAnalogInput, gain, zeroOffset);
  wire signed [31:0] v = mode ? a - scl(secondAnalogInput, gain, zeroOffset) : a;
  wire signed [31:0] on = onThreshold;
  wire signed [31:0] off = mode ? offThreshold : onThreshold + differential;
  wire cst = !mode || !(onFromBlock || offFromBlock);
  wire inWin = v >= on && v < off;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence hyst; evalEn && cst && on >= off; endsequence
  hold_noeval_a:
    assert property (!evalEn |=> $stable(q_q) && $stable(actualValue_q)) else $error("output moved");
  reset_clear_a:
    assert property (disable iff (1'b0) srst |=> !q_q && actualValue_q == 0) else $error("reset");
  scale_single_a:
    assert property (evalEn && !mode |=> actualValue_q == $past(v)) else $error("scaled value");
  scale_diff_a:
    assert property (evalEn && mode |=> actualValue_q == $past(v)) else $error("difference");
  set_above_a:
    assert property (hyst ##0 v > on |=> q_q) else $error("not set above on");
  clear_at_off_a:
    assert property (hyst ##0 v <= off |=> !q_q) else $error("not cleared at off");
  hold_band_a:
    assert property (hyst ##0 (v <= on && v > off) |=> $stable(q_q)) else $error("band hold");
  window_out_a:
    assert property (evalEn && cst && on < off |=> q_q == $past(inWin)) else $error("window");
  gain_error_a:
    assert property (evalEn && (gain > 1000 || gain < -1000) |=> paramError_q)
      else $error("gain range not flagged");
endmodule // analog_threshold_compare_properties
bind analog_threshold_compare analog_threshold_compare_properties i_props (
  .clk(clk), .srst(srst), .evalEn(evalEn), .mode(mode), .onFromBlock(onFromBlock),
  .offFromBlock(offFromBlock), .q_q(q_q), .paramError_q(paramError_q),
  .firstAnalogInput(firstAnalogInput), .secondAnalogInput(secondAnalogInput),
  .zeroOffset(zeroOffset), .onThreshold(onThreshold), .offThreshold(offThreshold),
  .differential(differential), .gain(gain), .actualValue_q(actualValue_q));

// *** analog_threshold_compare_test.sv ***
// self-checking bench for the analog threshold compare unit
`timescale 1ns/1ps
module analog_threshold_compare_test;
  logic clk = 0, srst = 1, evalEn = 0, mode = 0, onFromBlock = 0, offFromBlock = 0, load = 0;
  logic signed [15:0] firstAnalogInput = 0, secondAnalogInput = 0, zeroOffset = 0;
  logic signed [15:0] onThreshold = 0, offThreshold = 0, differential = 0;
  logic signed [11:0] gain = 0;
  logic [3:0] onBlockSel = 0, offBlockSel = 0;
  logic [1:0] decimals = 0;
  logic signed [31:0] loadVal = 0, actualValue_q, v, on, off, expV = 0, bv [8];
  logic [255:0] blockValues;
  logic q_q, paramError_q, expQ = 0, c;
  integer seed = 29, fails = 0, compares = 0, i;
  block_value_source i_block_value_source (.clk(clk), .load(load), .loadVal(loadVal),
    .blockValues(blockValues));
  analog_threshold_compare i_analog_threshold_compare (.clk(clk), .srst(srst),
    .evalEn(evalEn), .mode(mode), .firstAnalogInput(firstAnalogInput),
    .secondAnalogInput(secondAnalogInput), .gain(gain), .zeroOffset(zeroOffset),
    .onThreshold(onThreshold), .offThreshold(offThreshold), .differential(differential),
    .onFromBlock(onFromBlock), .offFromBlock(offFromBlock), .onBlockSel(onBlockSel),
    .offBlockSel(offBlockSel), .blockValues(blockValues), .decimals(decimals),
    .q_q(q_q), .actualValue_q(actualValue_q), .paramError_q(paramError_q));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic signed [31:0] scl(input logic signed [15:0] r);
    return r * gain / 100 + zeroOffset;
  endfunction
  function automatic logic signed [31:0] pick(input logic [3:0] s);
    return s < 8 ? bv[s] : 0;
  endfunction
  initial forever #20 clk = ~clk;
  initial begin
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      v = $random(seed) % 20001;
      load <= i < 8;
      loadVal <= v;
      if (i < 8) bv[7 - i] = v;
    end
    srst <= 0;
    @(negedge clk) chk("reset q", q_q, 0);
    repeat (400) begin
      @(posedge clk);
      c = $random(seed);
      evalEn <= ($random(seed) & 7) != 0;
      {mode, onFromBlock, offFromBlock, decimals, onBlockSel, offBlockSel} <= $random(seed);
      gain <= c ? 12'sh064 : $random(seed) % 1001;
      zeroOffset <= c ? 16'sh0000 : $random(seed) % 10001;
      firstAnalogInput <= $unsigned($random(seed)) % (c ? 4 : 1001);
      secondAnalogInput <= $unsigned($random(seed)) % (c ? 4 : 1001);
      onThreshold <= $random(seed) % (c ? 4 : 20001);
      offThreshold <= $random(seed) % (c ? 4 : 20001);
      differential <= $random(seed) % (c ? 4 : 20001);
      @(posedge clk);
      @(negedge clk);
      v = mode ? scl(firstAnalogInput) - scl(secondAnalogInput) : scl(firstAnalogInput);
      on = mode && onFromBlock ? pick(onBlockSel) : onThreshold;
      off = !mode ? onThreshold + differential : offFromBlock ? pick(offBlockSel) : offThreshold;
      if (evalEn) begin
        if (on < off) expQ = v >= on && v < off;
        else if (v > on) expQ = 1;
        else if (v <= off) expQ = 0;
        expV = v;
      end
      chk("q", q_q, expQ);
      chk("value", actualValue_q, expV);
      chk("error", paramError_q, 0);
    end
    // corner: gain beyond ten raises the error, then a reset in mid-run
    @(posedge clk);
    gain <= 12'sh7D0;
    evalEn <= 1;
    @(posedge clk);
    @(negedge clk) chk("gain error", paramError_q, 1);
    @(posedge clk);
    srst <= 1;
    evalEn <= 0;
    @(posedge clk);
    srst <= 0;
    @(negedge clk) chk("mid reset q", q_q, 0);
    chk("mid reset value", actualValue_q, 0);
    chk("mid reset error", paramError_q, 0);
    final_report();
  end
endmodule // analog_threshold_compare_test
